// [status_reporting_pkg.sv]
package status_reporting_pkg;

  localparam int COND_W = 16;
  localparam int STD_W = 8;
  localparam int CMD_W = 5;

  // Command codes issued by the command parser.
  localparam logic [4:0] CMD_QCOND_RD = 5'h01;
  localparam logic [4:0] CMD_QEVENT_RD = 5'h02;
  localparam logic [4:0] CMD_QENABLE_WR = 5'h03;
  localparam logic [4:0] CMD_QENABLE_RD = 5'h04;
  localparam logic [4:0] CMD_SEVENT_RD = 5'h05;
  localparam logic [4:0] CMD_SENABLE_WR = 5'h06;
  localparam logic [4:0] CMD_SENABLE_RD = 5'h07;
  localparam logic [4:0] CMD_OCOND_RD = 5'h08;
  localparam logic [4:0] CMD_OEVENT_RD = 5'h09;
  localparam logic [4:0] CMD_OENABLE_WR = 5'h0A;
  localparam logic [4:0] CMD_OENABLE_RD = 5'h0B;
  localparam logic [4:0] CMD_STB_RD = 5'h0C;
  localparam logic [4:0] CMD_SRMASK_WR = 5'h0D;
  localparam logic [4:0] CMD_SRMASK_RD = 5'h0E;
  localparam logic [4:0] CMD_CLEAR_STATUS = 5'h0F;
  localparam logic [4:0] CMD_OPC = 5'h10;
  localparam logic [4:0] CMD_OPC_QUERY = 5'h11;
  localparam logic [4:0] CMD_SERIAL_POLL = 5'h12;

  // Questionable data bit positions.
  localparam int Q_TEMP = 4;
  localparam int Q_RES = 9;
  localparam int Q_LOW = 11;
  localparam int Q_HIGH = 12;

  // Standard event bit positions.
  localparam int E_OPC = 0;
  localparam int E_QUERY = 2;
  localparam int E_EXEC = 4;
  localparam int E_CMD = 5;
  localparam int E_PON = 7;

  // Operation bit positions.
  localparam int O_MEAS = 4;
  localparam int O_AVAIL = 8;

  // Status byte bit positions.
  localparam int S_QSUM = 3;
  localparam int S_MAV = 4;
  localparam int S_ESUM = 5;
  localparam int S_RQS = 6;
  localparam int S_OSUM = 7;

  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [7:0] ZERO8 = 8'h00;

endpackage : status_reporting_pkg

// [status_reporting_service_request.sv]
// Overview of operation
// - Set questionable bit 11 when limits on and result below lower limit.
// - Set questionable bit 12 when limits on and result above upper limit.
// - Reading questionable or operation event returns its value, then clears it.
// - Enable registers read and write; only enabled events feed summaries.
// - Standard bit 0 sets when pending operations finish after OPC.
// - Standard bit 2 sets on empty-queue read or lost response data.
// - Standard bit 4 sets on out-of-context or out-of-range command.
// - Standard bit 5 sets when parser cannot recognise a command line.
// - Standard bit 7 sets after power comes on.
// - Operation condition bit 4 is one while a measurement runs.
// - Operation bit 8 sets on initiated result, clears on fetch.
// - A newly set bit in status byte and mask sets RQS and SRQ; never on serial link.
// - Serial poll returns status byte with RQS, then clears RQS and SRQ.
// - Status bit 3 summarises enabled questionable events.
// - Status bit 4 shows queued response data; zero on serial link.
// - Status bit 5 summarises enabled standard events.
// - RQS reads one for first poll per new reason; clears if reason goes.
// - Query read of status byte shows MSS in bit 6.
// - Status bit 7 summarises enabled operation events.
// - Clear-status clears events, summaries and both OPC waiting states.
// - OPC arms a wait setting bit 0; serial link gives command error.
// - OPC query arms a wait queuing a one; serial link gives command error.
// - Questionable and operation event bits latch on condition rising edges until read or cleared.
`timescale 1ns/1ps
module status_reporting_service_request #(
  parameter int COND_W = status_reporting_pkg::COND_W,
  parameter int STD_W = status_reporting_pkg::STD_W
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic serial_link,
  input wire logic cmd_valid,
  input wire logic [4:0] cmd_code,
  input wire logic [15:0] cmd_data,
  input wire logic result_valid,
  input wire logic limit_enable,
  input wire logic below_lower,
  input wire logic above_upper,
  input wire logic temp_error,
  input wire logic res_error,
  input wire logic meas_busy,
  input wire logic meas_done_init,
  input wire logic fetch_done,
  input wire logic exec_error,
  input wire logic cmd_error,
  input wire logic query_error,
  input wire logic ops_pending,
  input wire logic queue_has_data,
  output logic rsp_valid_r,
  output logic [15:0] rsp_data_r,
  output logic opc_push_r,
  output logic srq_r
);

  logic [COND_W-1:0] qcond_r;
  logic [COND_W-1:0] qcond_nxt;
  logic [COND_W-1:0] qevent_r;
  logic [COND_W-1:0] qevent_nxt;
  logic [COND_W-1:0] qenable_r;
  logic [COND_W-1:0] ocond_r;
  logic [COND_W-1:0] ocond_nxt;
  logic [COND_W-1:0] oevent_r;
  logic [COND_W-1:0] oevent_nxt;
  logic [COND_W-1:0] oenable_r;
  logic [STD_W-1:0] sevent_r;
  logic [STD_W-1:0] sevent_nxt;
  logic [STD_W-1:0] senable_r;
  logic [STD_W-1:0] srmask_r;
  logic [STD_W-1:0] svc_prev_r;
  logic meas_avail_r;
  logic pon_done_r;
  logic opc_cmd_wait_r;
  logic opc_qry_wait_r;

  function automatic logic is_cmd(input logic v, input logic [4:0] c,
                                  input logic [4:0] k);
    is_cmd = v && (c == k);
  endfunction : is_cmd

  wire rd_qcond = is_cmd(cmd_valid, cmd_code,
                         status_reporting_pkg::CMD_QCOND_RD);
  wire rd_qevent = is_cmd(cmd_valid, cmd_code,
                          status_reporting_pkg::CMD_QEVENT_RD);
  wire wr_qenable = is_cmd(cmd_valid, cmd_code,
                           status_reporting_pkg::CMD_QENABLE_WR);
  wire rd_qenable = is_cmd(cmd_valid, cmd_code,
                           status_reporting_pkg::CMD_QENABLE_RD);
  wire rd_sevent = is_cmd(cmd_valid, cmd_code,
                          status_reporting_pkg::CMD_SEVENT_RD);
  wire wr_senable = is_cmd(cmd_valid, cmd_code,
                           status_reporting_pkg::CMD_SENABLE_WR);
  wire rd_senable = is_cmd(cmd_valid, cmd_code,
                           status_reporting_pkg::CMD_SENABLE_RD);
  wire rd_ocond = is_cmd(cmd_valid, cmd_code,
                         status_reporting_pkg::CMD_OCOND_RD);
  wire rd_oevent = is_cmd(cmd_valid, cmd_code,
                          status_reporting_pkg::CMD_OEVENT_RD);
  wire wr_oenable = is_cmd(cmd_valid, cmd_code,
                           status_reporting_pkg::CMD_OENABLE_WR);
  wire rd_oenable = is_cmd(cmd_valid, cmd_code,
                           status_reporting_pkg::CMD_OENABLE_RD);
  wire rd_stb = is_cmd(cmd_valid, cmd_code,
                       status_reporting_pkg::CMD_STB_RD);
  wire wr_srmask = is_cmd(cmd_valid, cmd_code,
                          status_reporting_pkg::CMD_SRMASK_WR);
  wire rd_srmask = is_cmd(cmd_valid, cmd_code,
                          status_reporting_pkg::CMD_SRMASK_RD);
  wire clr_status = is_cmd(cmd_valid, cmd_code,
                           status_reporting_pkg::CMD_CLEAR_STATUS);
  wire opc_cmd = is_cmd(cmd_valid, cmd_code, status_reporting_pkg::CMD_OPC);
  wire opc_qry = is_cmd(cmd_valid, cmd_code,
                        status_reporting_pkg::CMD_OPC_QUERY);
  wire poll = is_cmd(cmd_valid, cmd_code,
                     status_reporting_pkg::CMD_SERIAL_POLL);

  // Conditions are refreshed when a new result arrives; limit bits need
  // the limit facility on.
  wire [COND_W-1:0] q_hit = COND_W'(
    ({{(COND_W-1){1'b0}}, limit_enable && below_lower}
      << status_reporting_pkg::Q_LOW) |
    ({{(COND_W-1){1'b0}}, limit_enable && above_upper}
      << status_reporting_pkg::Q_HIGH) |
    ({{(COND_W-1){1'b0}}, temp_error} << status_reporting_pkg::Q_TEMP) |
    ({{(COND_W-1){1'b0}}, res_error} << status_reporting_pkg::Q_RES));
  assign qcond_nxt = result_valid ? q_hit : qcond_r;

  // Measurement available sets on completion; a fetch in the same cycle
  // loses to the new completion.
  wire meas_avail_nxt = meas_done_init || (meas_avail_r && !fetch_done);
  assign ocond_nxt = COND_W'(
    ({{(COND_W-1){1'b0}}, meas_busy} << status_reporting_pkg::O_MEAS) |
    ({{(COND_W-1){1'b0}}, meas_avail_r} << status_reporting_pkg::O_AVAIL));

  wire [COND_W-1:0] q_rise = qcond_nxt & ~qcond_r;
  wire [COND_W-1:0] o_rise = ocond_nxt & ~ocond_r;

  // Clear on read or clear-status; a rising edge in the same cycle wins.
  assign qevent_nxt = (qevent_r & ~{COND_W{rd_qevent || clr_status}})
                      | q_rise;
  assign oevent_nxt = (oevent_r & ~{COND_W{rd_oevent || clr_status}})
                      | o_rise;

  wire opc_cmd_done = opc_cmd_wait_r && !ops_pending;
  wire opc_qry_done = opc_qry_wait_r && !ops_pending;
  wire opc_on_serial = (opc_cmd || opc_qry) && serial_link;
  wire [STD_W-1:0] s_set = STD_W'(
    ({{(STD_W-1){1'b0}}, opc_cmd_done && !serial_link}
      << status_reporting_pkg::E_OPC) |
    ({{(STD_W-1){1'b0}}, query_error}
      << status_reporting_pkg::E_QUERY) |
    ({{(STD_W-1){1'b0}}, exec_error} << status_reporting_pkg::E_EXEC) |
    ({{(STD_W-1){1'b0}}, cmd_error || opc_on_serial}
      << status_reporting_pkg::E_CMD) |
    ({{(STD_W-1){1'b0}}, !pon_done_r} << status_reporting_pkg::E_PON));
  assign sevent_nxt = (sevent_r & ~{STD_W{rd_sevent || clr_status}})
                      | s_set;

  wire qsum = |(qevent_r & qenable_r);
  wire esum = |(sevent_r & senable_r);
  wire osum = |(oevent_r & oenable_r);
  wire mav = queue_has_data && !serial_link;

  // Status byte without bit 6; bit 6 is filled per read path.
  wire [STD_W-1:0] stb_base = STD_W'(
    ({{(STD_W-1){1'b0}}, qsum} << status_reporting_pkg::S_QSUM) |
    ({{(STD_W-1){1'b0}}, mav} << status_reporting_pkg::S_MAV) |
    ({{(STD_W-1){1'b0}}, esum} << status_reporting_pkg::S_ESUM) |
    ({{(STD_W-1){1'b0}}, osum} << status_reporting_pkg::S_OSUM));
  wire [STD_W-1:0] svc_bits = stb_base & srmask_r;
  wire svc_any = |svc_bits;
  wire new_reason = |(svc_bits & ~svc_prev_r);
  wire mss = svc_any && !serial_link;

  // A new reason wins over a poll in the same cycle; RQS also drops when
  // every reason disappears.
  wire rqs_nxt = serial_link ? 1'b0 :
                 new_reason ? 1'b1 :
                 (poll || !svc_any) ? 1'b0 : srq_r;

  wire [STD_W-1:0] stb_poll = STD_W'(stb_base |
    ({{(STD_W-1){1'b0}}, srq_r} << status_reporting_pkg::S_RQS));
  wire [STD_W-1:0] stb_query = STD_W'(stb_base |
    ({{(STD_W-1){1'b0}}, mss} << status_reporting_pkg::S_RQS));

  wire rd_any = rd_qcond || rd_qevent || rd_qenable || rd_sevent ||
                rd_senable || rd_ocond || rd_oevent || rd_oenable ||
                rd_stb || rd_srmask || poll;
  wire [15:0] rd_val =
    rd_qcond ? 16'(qcond_r) :
    rd_qevent ? 16'(qevent_r) :
    rd_qenable ? 16'(qenable_r) :
    rd_sevent ? 16'(sevent_r) :
    rd_senable ? 16'(senable_r) :
    rd_ocond ? 16'(ocond_r) :
    rd_oevent ? 16'(oevent_r) :
    rd_oenable ? 16'(oenable_r) :
    rd_stb ? 16'(stb_query) :
    rd_srmask ? 16'(srmask_r) :
    poll ? 16'(stb_poll) : status_reporting_pkg::ZERO16;

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      qcond_r <= COND_W'(status_reporting_pkg::ZERO16);
      qevent_r <= COND_W'(status_reporting_pkg::ZERO16);
      ocond_r <= COND_W'(status_reporting_pkg::ZERO16);
      oevent_r <= COND_W'(status_reporting_pkg::ZERO16);
      sevent_r <= STD_W'(status_reporting_pkg::ZERO8);
      meas_avail_r <= 1'b0;
      pon_done_r <= 1'b0;
    end
    else
    begin
      qcond_r <= qcond_nxt;
      qevent_r <= qevent_nxt;
      ocond_r <= ocond_nxt;
      oevent_r <= oevent_nxt;
      sevent_r <= sevent_nxt;
      meas_avail_r <= meas_avail_nxt;
      pon_done_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      qenable_r <= COND_W'(status_reporting_pkg::ZERO16);
      oenable_r <= COND_W'(status_reporting_pkg::ZERO16);
      senable_r <= STD_W'(status_reporting_pkg::ZERO8);
      srmask_r <= STD_W'(status_reporting_pkg::ZERO8);
    end
    else
    begin
      if (wr_qenable)
        qenable_r <= COND_W'(cmd_data);
      if (wr_oenable)
        oenable_r <= COND_W'(cmd_data);
      if (wr_senable)
        senable_r <= STD_W'(cmd_data);
      if (wr_srmask)
        srmask_r <= STD_W'(cmd_data);
    end
  end

  // Operation-complete waits; clear-status returns both to idle.
  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      opc_cmd_wait_r <= 1'b0;
      opc_qry_wait_r <= 1'b0;
      opc_push_r <= 1'b0;
    end
    else
    begin
      opc_cmd_wait_r <= !clr_status && ((opc_cmd && !serial_link) ||
                        (opc_cmd_wait_r && !opc_cmd_done));
      opc_qry_wait_r <= !clr_status && ((opc_qry && !serial_link) ||
                        (opc_qry_wait_r && !opc_qry_done));
      opc_push_r <= opc_qry_done && !clr_status;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!nrst)
    begin
      svc_prev_r <= STD_W'(status_reporting_pkg::ZERO8);
      srq_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= status_reporting_pkg::ZERO16;
    end
    else
    begin
      svc_prev_r <= svc_bits;
      srq_r <= rqs_nxt;
      rsp_valid_r <= rd_any;
      rsp_data_r <= rd_val;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  chk_low_limit_set: assert property (
    result_valid && limit_enable && below_lower
    |=> qcond_r[status_reporting_pkg::Q_LOW])
    else $error("low limit bit not set");
  chk_high_limit_clear: assert property (
    result_valid && !limit_enable
    |=> !qcond_r[status_reporting_pkg::Q_HIGH])
    else $error("high limit bit set with limits off");
  chk_event_read_clear: assert property (
    rd_qevent && !clr_status
    |=> rsp_valid_r && rsp_data_r == 16'($past(qevent_r))
        && qevent_r == $past(q_rise))
    else $error("questionable event read wrong");
  chk_enable_readback: assert property (
    wr_oenable ##1 rd_oenable |=> rsp_data_r == $past(cmd_data, 2))
    else $error("operation enable readback wrong");
  chk_opc_done_bit: assert property (
    opc_cmd_wait_r && !ops_pending && !serial_link
    |=> sevent_r[status_reporting_pkg::E_OPC] && !opc_cmd_wait_r)
    else $error("operation complete bit missing");
  chk_query_err_bit: assert property (
    query_error |=> sevent_r[status_reporting_pkg::E_QUERY])
    else $error("query error bit missing");
  chk_exec_err_bit: assert property (
    exec_error |=> sevent_r[status_reporting_pkg::E_EXEC])
    else $error("execution error bit missing");
  chk_cmd_err_bit: assert property (
    cmd_error || (opc_cmd && serial_link)
    |=> sevent_r[status_reporting_pkg::E_CMD])
    else $error("command error bit missing");
  chk_measuring_follow: assert property (
    ##1 ocond_r[status_reporting_pkg::O_MEAS] == $past(meas_busy))
    else $error("measuring bit does not follow");
  chk_srq_raise: assert property (
    new_reason && !serial_link |=> srq_r)
    else $error("service request not raised");
  chk_poll_release: assert property (
    poll && !new_reason |=> !srq_r ##1 (!srq_r || $past(new_reason)))
    else $error("poll did not release service request");
  chk_mss_query: assert property (
    rd_stb |=> rsp_data_r[status_reporting_pkg::S_RQS] == $past(mss))
    else $error("summary status bit wrong");
  chk_opc_query_push: assert property (
    opc_qry && !serial_link ##1 !ops_pending && !clr_status
    |=> opc_push_r)
    else $error("operation complete query did not queue");

  // Register, summary, service request, completion and clear-status checks.
  chk_oevent_read_clear: assert property (
    rd_oevent && !clr_status
    |=> rsp_valid_r && rsp_data_r == 16'($past(oevent_r))
        && oevent_r == $past(o_rise))
    else $error("operation event read wrong");
  chk_qenable_write: assert property (
    wr_qenable |=> qenable_r == COND_W'($past(cmd_data)))
    else $error("questionable enable write lost");
  chk_power_on_bit: assert property (
    !pon_done_r |=> sevent_r[status_reporting_pkg::E_PON])
    else $error("power on bit missing");
  chk_avail_set: assert property (
    meas_done_init |=> meas_avail_r)
    else $error("measurement available not set");
  chk_avail_fetch_clear: assert property (
    fetch_done && !meas_done_init |=> !meas_avail_r)
    else $error("measurement available not cleared");
  chk_stb_unused_zero: assert property (
    rd_stb || poll
    |=> rsp_data_r[15:STD_W] == '0
        && rsp_data_r[status_reporting_pkg::S_QSUM-1:0] == '0)
    else $error("unused status byte bits set");
  chk_serial_stb_bits: assert property (
    rd_stb && serial_link
    |=> !rsp_data_r[status_reporting_pkg::S_MAV]
        && !rsp_data_r[status_reporting_pkg::S_RQS])
    else $error("serial status byte shows bus bits");
  chk_srq_serial_low: assert property (
    serial_link |=> !srq_r)
    else $error("service request on serial link");
  chk_srq_reason_gone: assert property (
    !svc_any |=> !srq_r)
    else $error("service request without reason");
  chk_qsum_masked: assert property (
    rd_stb && (qevent_r & qenable_r) == '0
    |=> !rsp_data_r[status_reporting_pkg::S_QSUM])
    else $error("questionable summary not masked");
  chk_esum_masked: assert property (
    rd_stb && (sevent_r & senable_r) == '0
    |=> !rsp_data_r[status_reporting_pkg::S_ESUM])
    else $error("standard summary not masked");
  chk_osum_masked: assert property (
    rd_stb && (oevent_r & oenable_r) == '0
    |=> !rsp_data_r[status_reporting_pkg::S_OSUM])
    else $error("operation summary not masked");
  chk_cls_waits_idle: assert property (
    clr_status |=> !opc_cmd_wait_r && !opc_qry_wait_r)
    else $error("clear status left a wait armed");
  chk_cls_events_clear: assert property (
    clr_status
    |=> qevent_r == $past(q_rise) && oevent_r == $past(o_rise))
    else $error("clear status left events");
  chk_opc_serial_ignore: assert property (
    (opc_cmd || opc_qry) && serial_link
    && !opc_cmd_wait_r && !opc_qry_wait_r
    |=> !opc_cmd_wait_r && !opc_qry_wait_r)
    else $error("operation complete armed on serial link");
  chk_event_latch_rise: assert property (
    result_valid && res_error && !qcond_r[status_reporting_pkg::Q_RES]
    |=> qevent_r[status_reporting_pkg::Q_RES])
    else $error("event bit missed a rising condition");

endmodule : status_reporting_service_request

// [ctl_model.sv]
`timescale 1ns/1ps
module ctl_model (
  input wire logic core_clk,
  output logic cmd_valid,
  output logic [4:0] cmd_code,
  output logic [15:0] cmd_data
);

  initial
  begin
    cmd_valid = 1'b0;
    cmd_code = 5'h00;
    cmd_data = 16'h0000;
  end

  // Idle command lines carry the inverse of the last value, never a copy.
  task automatic send(input logic [4:0] code, input logic [15:0] data);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_data = data;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_code = ~code;
    cmd_data = ~data;
  endtask : send

  // Two commands on consecutive edges; valid stays high between them.
  task automatic send_pair(input logic [4:0] code_a,
                           input logic [15:0] data_a,
                           input logic [4:0] code_b,
                           input logic [15:0] data_b);
    @(negedge core_clk);
    cmd_valid = 1'b1;
    cmd_code = code_a;
    cmd_data = data_a;
    @(negedge core_clk);
    cmd_code = code_b;
    cmd_data = data_b;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_code = ~code_b;
    cmd_data = ~data_b;
  endtask : send_pair

  task automatic poll();
    send(status_reporting_pkg::CMD_SERIAL_POLL, 16'h0000);
  endtask : poll

endmodule : ctl_model

// [test_status_reporting_service_request.sv]
`timescale 1ns/1ps
module test_status_reporting_service_request;
  logic core_clk, nrst, serial_link, cmd_valid;
  logic [4:0] cmd_code;
  logic [15:0] cmd_data;
  logic result_valid, limit_enable, below_lower, above_upper;
  logic temp_error, res_error, meas_busy, meas_done_init, fetch_done;
  logic exec_error, cmd_error, query_error, ops_pending, queue_has_data;
  logic rsp_valid_r, opc_push_r, srq_r;
  logic [15:0] rsp_data_r;
  logic [4:0] wc [4];
  int fx [4] = '{32'h1800, 32'h00B5, 32'h0110, 32'h0020};
  int en [4] = '{0, 0, 0, 0};
  int qev = 0, sev = 0, oev = 0, qc = 0, fail_count = 0, checks = 0;

  always #20 core_clk = ~core_clk;

  ctl_model u_ctl (.core_clk(core_clk), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_data(cmd_data));

  status_reporting_service_request u_dut (
    .core_clk(core_clk), .nrst(nrst), .serial_link(serial_link),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_data(cmd_data),
    .result_valid(result_valid), .limit_enable(limit_enable),
    .below_lower(below_lower), .above_upper(above_upper),
    .temp_error(temp_error), .res_error(res_error),
    .meas_busy(meas_busy), .meas_done_init(meas_done_init),
    .fetch_done(fetch_done), .exec_error(exec_error),
    .cmd_error(cmd_error), .query_error(query_error),
    .ops_pending(ops_pending), .queue_has_data(queue_has_data),
    .rsp_valid_r(rsp_valid_r), .rsp_data_r(rsp_data_r),
    .opc_push_r(opc_push_r), .srq_r(srq_r));

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask : tick

  task automatic pls(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask : pls

  task automatic chk_rsp(input int exp);
    checks++;
    if (rsp_valid_r !== 1'b1 || rsp_data_r !== 16'(exp))
    begin
      fail_count++;
      $display("[ERR] %0t answer %h want %h", $time, rsp_data_r, 16'(exp));
    end
  endtask : chk_rsp

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t flag %b want %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic rd(input logic [4:0] code, input int exp);
    u_ctl.send(code, 16'h0000);
    chk_rsp(exp);
  endtask : rd

  function automatic int sbase();
    int s;
    s = (qev & en[0]) != 0 ? 8 : 0;
    s |= (sev & en[1]) != 0 ? 32 : 0;
    s |= (oev & en[2]) != 0 ? 128 : 0;
    s |= queue_has_data === 1'b1 && serial_link === 1'b0 ? 16 : 0;
    return s;
  endfunction : sbase

  function automatic int stq();
    return sbase() | ((sbase() & en[3]) != 0 && !serial_link ? 64 : 0);
  endfunction : stq

  task automatic result(input logic lim, lo, hi, te, re);
    int c;
    c = (lim & lo ? 32'h0800 : 0) | (lim & hi ? 32'h1000 : 0);
    c |= (te ? 32'h0010 : 0) | (re ? 32'h0200 : 0);
    @(negedge core_clk);
    {result_valid, limit_enable, below_lower} = {1'b1, lim, lo};
    {above_upper, temp_error, res_error} = {hi, te, re};
    qev |= c & ~qc;
    qc = c;
    tick(1);
    result_valid = 1'b0;
    tick(2);
  endtask : result

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  initial
  begin
    int w;
    int n;
    {core_clk, nrst, serial_link, result_valid, limit_enable} = 5'h00;
    {below_lower, above_upper, temp_error, res_error, meas_busy} = 5'h00;
    {meas_done_init, fetch_done, exec_error, cmd_error} = 4'h0;
    {query_error, ops_pending, queue_has_data} = 3'h0;
    wc = '{status_reporting_pkg::CMD_QENABLE_WR,
      status_reporting_pkg::CMD_SENABLE_WR,
      status_reporting_pkg::CMD_OENABLE_WR,
      status_reporting_pkg::CMD_SRMASK_WR};
    void'($urandom(17432));
    tick(16);
    nrst = 1'b1;
    sev = 128;
    tick(2);
    rd(status_reporting_pkg::CMD_SEVENT_RD, sev);
    sev = 0;
    rd(status_reporting_pkg::CMD_SEVENT_RD, 0);
    $display("test power_on done");
    for (int i = 0; i < 4; i++)
      for (int j = 0; j < 2; j++)
      begin
        w = j ? fx[i] : $urandom();
        u_ctl.send(wc[i], 16'(w));
        en[i] = w & (i % 2 ? 32'h00FF : 32'hFFFF);
        rd(wc[i] + 5'h01, en[i]);
      end
    u_ctl.send_pair(status_reporting_pkg::CMD_OENABLE_WR, 16'(fx[2]),
      status_reporting_pkg::CMD_OENABLE_RD, 16'h0000);
    chk_rsp(en[2]);
    $display("test enables done");
    result(1'b1, 1'b1, 1'b0, 1'($urandom()), 1'($urandom()));
    rd(status_reporting_pkg::CMD_QCOND_RD, qc);
    rd(status_reporting_pkg::CMD_STB_RD, stq());
    rd(status_reporting_pkg::CMD_QEVENT_RD, qev);
    qev = 0;
    rd(status_reporting_pkg::CMD_STB_RD, stq());
    result(1'b1, 1'b0, 1'b1, 1'b1, 1'b1);
    rd(status_reporting_pkg::CMD_QCOND_RD, qc);
    result(1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    rd(status_reporting_pkg::CMD_QEVENT_RD, qev);
    qev = 0;
    $display("test questionable done");
    meas_busy = 1'b1;
    tick(2);
    rd(status_reporting_pkg::CMD_OCOND_RD, 32'h0010);
    meas_busy = 1'b0;
    pls(meas_done_init);
    oev = 32'h0110;
    tick(2);
    rd(status_reporting_pkg::CMD_OCOND_RD, 32'h0100);
    rd(status_reporting_pkg::CMD_STB_RD, stq());
    pls(fetch_done);
    tick(2);
    rd(status_reporting_pkg::CMD_OCOND_RD, 0);
    rd(status_reporting_pkg::CMD_OEVENT_RD, oev);
    oev = 0;
    $display("test operation done");
    chk_bit(srq_r, 1'b0);
    pls(exec_error);
    sev = 32'h0010;
    tick(3);
    chk_bit(srq_r, 1'b1);
    rd(status_reporting_pkg::CMD_STB_RD, stq());
    u_ctl.poll();
    chk_rsp(sbase() | 64);
    tick(1);
    chk_bit(srq_r, 1'b0);
    u_ctl.poll();
    chk_rsp(sbase());
    pls(cmd_error);
    pls(query_error);
    sev = 32'h0034;
    tick(3);
    chk_bit(srq_r, 1'b0);
    rd(status_reporting_pkg::CMD_SEVENT_RD, sev);
    sev = 0;
    rd(status_reporting_pkg::CMD_STB_RD, stq());
    pls(exec_error);
    tick(3);
    chk_bit(srq_r, 1'b1);
    rd(status_reporting_pkg::CMD_SEVENT_RD, 32'h0010);
    tick(2);
    chk_bit(srq_r, 1'b0);
    $display("test service_request done");
    queue_has_data = 1'b1;
    tick(2);
    rd(status_reporting_pkg::CMD_STB_RD, stq());
    serial_link = 1'b1;
    tick(2);
    rd(status_reporting_pkg::CMD_STB_RD, stq());
    u_ctl.send(status_reporting_pkg::CMD_OPC, 16'h0000);
    u_ctl.send(status_reporting_pkg::CMD_OPC_QUERY, 16'h0000);
    tick(3);
    chk_bit(srq_r, 1'b0);
    rd(status_reporting_pkg::CMD_SEVENT_RD, 32'h0020);
    {serial_link, queue_has_data, ops_pending} = 3'b001;
    u_ctl.send(status_reporting_pkg::CMD_OPC, 16'h0000);
    tick(3);
    rd(status_reporting_pkg::CMD_SEVENT_RD, 0);
    ops_pending = 1'b0;
    tick(3);
    rd(status_reporting_pkg::CMD_SEVENT_RD, 1);
    ops_pending = 1'b1;
    u_ctl.send(status_reporting_pkg::CMD_OPC_QUERY, 16'h0000);
    ops_pending = 1'b0;
    n = 0;
    repeat (8)
    begin
      @(negedge core_clk);
      n += opc_push_r === 1'b1;
    end
    chk_bit(n == 1, 1'b1);
    $display("test completion done");
    ops_pending = 1'b1;
    u_ctl.send(status_reporting_pkg::CMD_OPC, 16'h0000);
    pls(exec_error);
    result(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    u_ctl.send(status_reporting_pkg::CMD_CLEAR_STATUS, 16'h0000);
    ops_pending = 1'b0;
    {sev, qev} = 64'h0;
    tick(3);
    chk_bit(srq_r, 1'b0);
    rd(status_reporting_pkg::CMD_SEVENT_RD, 0);
    rd(status_reporting_pkg::CMD_QEVENT_RD, 0);
    rd(status_reporting_pkg::CMD_STB_RD, stq());
    $display("test clear_status done");
    final_report();
  end

endmodule : test_status_reporting_service_request
